// ### shared/irlc_pkg.sv
// Constants and carrier types for the isolated RS485 link control block
package irlc_pkg;
	// Clock and sample rates, in MHz
	localparam int CLK_MHZ = 10;
	localparam int SAMPLE_MHZ = 4;
	// Fractional divider that makes the sample enable
	localparam int ACC_W = 4;
	localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(SAMPLE_MHZ);
	localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_MHZ);
	localparam logic [ACC_W-1:0] ACC_RST = 4'h0;
	// Barrier timing, as figures and as cycle counts
	localparam int SAMPLE_JITTER_NS = 250;
	localparam int DATA_DLY_NS = 600;
	localparam int DATA_DLY_CYC = DATA_DLY_NS * CLK_MHZ / 1000;
	localparam int DE_DLY_NS = 875;
	localparam int DE_TOL_NS = 125;
	localparam int DE_DLY_CYC = DE_DLY_NS * CLK_MHZ / 1000;
	localparam int START_MIN_NS = 1000;
	localparam int START_MAX_NS = 2000;
	localparam int START_CYC = (START_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int TOF_NS = 1200;
	localparam int TOF_CYC = TOF_NS * CLK_MHZ / 1000;
	localparam int CNT_W = 5;
	localparam int FIFO_DEPTH = 16;
	// Values after reset
	localparam logic RX_DATA_RST = 1'h1;
	localparam logic FAULT_RST = 1'h1;
	// One barrier sample from the logic side
	typedef struct packed {
		logic drive_en;
		logic data;
	} irlc_sample_t;
	// Fault causes reported by the analog detectors
	typedef struct packed {
		logic uv_logic;
		logic uv_iso;
		logic thermal;
	} irlc_fault_t;
endpackage

// ### hdl/irlc_top.sv
// Isolated RS485 link control: barrier FIFO and top-level control logic
`timescale 1ns/1ps

module irlc_fifo #(
	parameter int W = 2,
	parameter int D = 16
) (
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic [W-1:0] in_data, // Write word
	input wire logic in_valid, // Write request
	output logic in_ready, // Room for a word
	output logic [W-1:0] out_data, // Oldest word
	output logic out_valid, // Word available
	input wire logic out_ready // Reader takes the word
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic push;
	logic pop;

	// Extra pointer bit tells full from empty
	assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
	assign out_valid = wr_q != rd_q;
	assign out_data = mem[rd_q[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	// Pointers
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule

module irlc_top (
	input wire logic sys_clk, // 10 MHz clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic tx_data_in, // Transmit data from host
	input wire logic tx_drive_enable, // Driver enable from host
	input wire logic rx_out_enable_fault_in, // Enable pin level, low enables
	output logic rx_out_enable_fault_out, // Weak drive: high means fault
	output logic rx_out_enable_fault_oe, // Weak drive enable
	output logic rx_data_out, // Logic-side receive data
	output logic rx_data_oe, // Receive data drive enable
	input wire logic line_rx_level, // Receiver comparator result
	input wire logic line_rx_failsafe, // Pair open or shorted
	output logic iso_rx_data_out, // Isolated-side receive data
	input wire logic slow_edge_select_n, // Low selects slow edges
	output logic slow_edge_active, // Driver in slow edge mode
	output logic drv_y_out, // Noninverting driver output
	output logic drv_z_out, // Inverting driver output
	output logic drv_oe, // Driver enable for both outputs
	input wire irlc_pkg::irlc_fault_t fault_in, // Detector levels
	output logic fifo_in_ready // Barrier buffer has room
);
	import irlc_pkg::*;

	logic [ACC_W-1:0] acc_q;
	logic tick_q;
	irlc_sample_t smp_q;
	logic smp_pend_q;
	irlc_sample_t fifo_out;
	logic fifo_out_valid;
	logic fifo_rdy;
	logic comm_ok;
	logic [CNT_W-1:0] start_cnt_q;
	logic link_up_q;
	logic iso_di_q;
	logic iso_de_q;
	logic [DATA_DLY_CYC-1:0] di_pipe_q;
	logic [DE_DLY_CYC-1:0] de_pipe_q;
	logic iso_rx_q;
	logic [DATA_DLY_CYC-1:0] ret_vld_q;
	logic [DATA_DLY_CYC-1:0] ret_dat_q;
	logic ret_arrive;
	logic rx_hold_q;
	logic [CNT_W-1:0] tof_cnt_q;
	logic timeout_q;
	logic fault_now;

	// Sample enable, 4 of every 10 cycles, free running
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			acc_q <= ACC_RST;
			tick_q <= 1'h0;
		end else if (acc_q >= ACC_MOD - ACC_STEP) begin
			acc_q <= acc_q + ACC_STEP - ACC_MOD;
			tick_q <= 1'h1;
		end else begin
			acc_q <= acc_q + ACC_STEP;
			tick_q <= 1'h0;
		end
	end

	// Logic-side sampler; a full buffer holds the sample and skips ticks
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			smp_q <= '0;
			smp_pend_q <= 1'h0;
		end else if (smp_pend_q && !fifo_rdy) begin
			smp_pend_q <= 1'h1;
		end else if (tick_q) begin
			smp_q <= '{drive_en: tx_drive_enable, data: tx_data_in};
			smp_pend_q <= 1'h1;
		end else begin
			smp_pend_q <= 1'h0;
		end
	end

	// Encoded samples wait here until the barrier carries them
	irlc_fifo #(
		.W($bits(irlc_sample_t)),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk(sys_clk),
		.rst(sys_rst),
		.in_data(smp_q),
		.in_valid(smp_pend_q),
		.in_ready(fifo_rdy),
		.out_data(fifo_out),
		.out_valid(fifo_out_valid),
		.out_ready(link_up_q)
	);

	// Barrier usable only with both supplies good and no overtemperature
	assign comm_ok = !fault_in.uv_logic && !fault_in.uv_iso && !fault_in.thermal;

	// Link start-up: traffic resumes only after a settled interval
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !comm_ok) begin
			start_cnt_q <= '0;
			link_up_q <= 1'h0;
		end else if (start_cnt_q == CNT_W'(START_CYC - 1)) begin
			link_up_q <= 1'h1;
		end else begin
			start_cnt_q <= start_cnt_q + 1'b1;
		end
	end

	// Isolated side decodes one sample per cycle, draining any backlog fast
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			iso_di_q <= 1'h0;
			iso_de_q <= 1'h0;
		end else if (!link_up_q) begin
			iso_de_q <= 1'h0;
		end else if (fifo_out_valid) begin
			iso_di_q <= fifo_out.data;
			iso_de_q <= fifo_out.drive_en;
		end
	end

	// Enable path runs longer than data because of its encoding
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			di_pipe_q <= '0;
			de_pipe_q <= '0;
		end else begin
			di_pipe_q <= {di_pipe_q[DATA_DLY_CYC-2:0], iso_di_q};
			de_pipe_q <= {de_pipe_q[DE_DLY_CYC-2:0], iso_de_q};
		end
	end

	// Line driver; released whenever the link is down or overheated
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			drv_y_out <= 1'h0;
			drv_z_out <= 1'h1;
			drv_oe <= 1'h0;
			slow_edge_active <= 1'h0;
		end else begin
			drv_y_out <= di_pipe_q[DATA_DLY_CYC-1];
			drv_z_out <= !di_pipe_q[DATA_DLY_CYC-1];
			drv_oe <= de_pipe_q[DE_DLY_CYC-1] && link_up_q && comm_ok;
			slow_edge_active <= !slow_edge_select_n;
		end
	end

	// Isolated receiver ignores the enable pin entirely
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			iso_rx_q <= RX_DATA_RST;
		end else begin
			iso_rx_q <= line_rx_failsafe || line_rx_level;
		end
	end
	assign iso_rx_data_out = iso_rx_q;

	// Return path; in-flight samples are lost when the link drops
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !link_up_q) begin
			ret_vld_q <= '0;
			ret_dat_q <= '1;
		end else begin
			ret_vld_q <= {ret_vld_q[DATA_DLY_CYC-2:0], tick_q};
			ret_dat_q <= {ret_dat_q[DATA_DLY_CYC-2:0], iso_rx_q};
		end
	end
	assign ret_arrive = ret_vld_q[DATA_DLY_CYC-1];

	// Watchdog on isolated-side traffic
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rx_hold_q <= RX_DATA_RST;
			tof_cnt_q <= '0;
			timeout_q <= FAULT_RST;
		end else if (ret_arrive) begin
			rx_hold_q <= ret_dat_q[DATA_DLY_CYC-1];
			tof_cnt_q <= '0;
			timeout_q <= 1'h0;
		end else if (tof_cnt_q == CNT_W'(TOF_CYC - 1)) begin
			timeout_q <= 1'h1;
		end else begin
			tof_cnt_q <= tof_cnt_q + 1'b1;
		end
	end

	// A down link counts as a fault so the flag waits for the restart
	assign fault_now = !comm_ok || timeout_q || !link_up_q;

	// Logic-side outputs; weak fault drive is always on so it can be polled
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rx_data_out <= RX_DATA_RST;
			rx_data_oe <= 1'h0;
			rx_out_enable_fault_out <= FAULT_RST;
			rx_out_enable_fault_oe <= 1'h1;
			fifo_in_ready <= 1'h1;
		end else begin
			rx_data_out <= fault_now || rx_hold_q;
			rx_data_oe <= !rx_out_enable_fault_in;
			rx_out_enable_fault_out <= fault_now;
			rx_out_enable_fault_oe <= 1'h1;
			fifo_in_ready <= fifo_rdy;
		end
	end

	// Ticks come 2 or 3 cycles apart, so after the quiet cycle one or two more
	localparam int A_TICK_LO = 1;
	localparam int A_TICK_HI = 2;
	localparam int A_DI_DEPTH = DATA_DLY_CYC + 1;
	localparam int A_DE_DEPTH = DE_DLY_CYC + 1;

	sequence s_tick_gap;
		##[A_TICK_LO:A_TICK_HI] tick_q;
	endsequence
	sequence s_silent_end;
		tof_cnt_q == CNT_W'(TOF_CYC - 1) && !ret_arrive;
	endsequence

	property p_drv_off;
		@(posedge sys_clk) disable iff (sys_rst) !comm_ok |=> !drv_oe;
	endproperty
	a_drv_off: assert property (p_drv_off) else $error("driver on during fault");
	property p_drv_compl;
		@(posedge sys_clk) disable iff (sys_rst) drv_oe |-> drv_z_out == !drv_y_out;
	endproperty
	a_drv_compl: assert property (p_drv_compl) else $error("driver outputs not complementary");
	property p_de_path;
		@(posedge sys_clk) disable iff (sys_rst) drv_oe |-> $past(iso_de_q, A_DE_DEPTH);
	endproperty
	a_de_path: assert property (p_de_path) else $error("driver on without delayed enable");
	property p_di_path;
		@(posedge sys_clk) disable iff (sys_rst)
			1'b1 |-> ##A_DI_DEPTH drv_y_out == $past(iso_di_q, A_DI_DEPTH);
	endproperty
	a_di_path: assert property (p_di_path) else $error("data delay wrong");
	property p_rx_oe;
		@(posedge sys_clk) disable iff (sys_rst)
			rx_out_enable_fault_in |=> !rx_data_oe ##0 rx_out_enable_fault_oe;
	endproperty
	a_rx_oe: assert property (p_rx_oe) else $error("receive data driven while disabled");
	property p_iso_rx;
		@(posedge sys_clk) disable iff (sys_rst)
			1'b1 |=> iso_rx_data_out == ($past(line_rx_level) || $past(line_rx_failsafe));
	endproperty
	a_iso_rx: assert property (p_iso_rx) else $error("isolated receive output wrong");
	property p_slow;
		@(posedge sys_clk) disable iff (sys_rst) 1'b1 |=> slow_edge_active != $past(slow_edge_select_n);
	endproperty
	a_slow: assert property (p_slow) else $error("edge mode wrong");
	property p_fault_rx;
		@(posedge sys_clk) disable iff (sys_rst)
			(fault_in != '0) |=> rx_data_out && rx_out_enable_fault_out;
	endproperty
	a_fault_rx: assert property (p_fault_rx) else $error("fault not shown");
	property p_block;
		@(posedge sys_clk) disable iff (sys_rst) fault_in.uv_iso |=> !link_up_q;
	endproperty
	a_block: assert property (p_block) else $error("link up under low supply");
	property p_start;
		@(posedge sys_clk) disable iff (sys_rst)
			$rose(link_up_q) |-> $past(comm_ok) && $past(comm_ok, START_CYC);
	endproperty
	a_start: assert property (p_start) else $error("link came up too early");
	property p_tof;
		@(posedge sys_clk) disable iff (sys_rst) s_silent_end |=> timeout_q ##1 rx_out_enable_fault_out;
	endproperty
	a_tof: assert property (p_tof) else $error("time-out not raised");
	property p_tick;
		@(posedge sys_clk) disable iff (sys_rst) tick_q |=> !tick_q ##0 s_tick_gap;
	endproperty
	a_tick: assert property (p_tick) else $error("sample rate wrong");
	property p_clear;
		@(posedge sys_clk) disable iff (sys_rst) $fell(rx_out_enable_fault_out) |-> $past(link_up_q);
	endproperty
	a_clear: assert property (p_clear) else $error("fault cleared before restart");
endmodule

// ### verification/irlc_line_node.sv
// Remote bus nodes and the twisted pair seen from the isolated side
`timescale 1ns/1ps
module irlc_line_node (
	input wire logic sys_clk, // Bench clock, only for the float pattern
	input wire logic drv_y_out, // Device true output
	input wire logic drv_oe, // Device driver enable
	input wire logic node_en, // Remote node drives the pair
	input wire logic node_tx, // Remote node data
	input wire logic pair_open, // Pair broken or shorted
	output logic line_rx_level, // Comparator result
	output logic line_rx_failsafe // No valid differential signal
);
	logic flip_q = 1'h0;
	// An undriven comparator wanders, so never show a stale level
	always_ff @(posedge sys_clk) begin
		flip_q <= !flip_q;
	end
	// Remote node wins over loopback; nobody driving reads as open pair
	always_comb begin
		line_rx_failsafe = pair_open || !(node_en || drv_oe);
		if (line_rx_failsafe) begin
			line_rx_level = flip_q;
		end else if (node_en) begin
			line_rx_level = node_tx;
		end else begin
			line_rx_level = drv_y_out;
		end
	end
endmodule

// ### verification/irlc_top_test.sv
// Self-checking bench for the isolated RS485 link control block
`timescale 1ns/1ps
module irlc_top_test;
	import irlc_pkg::*;
	logic sys_clk = 1'h0, sys_rst = 1'h1, tx_data_in = 1'h0, tx_drive_enable = 1'h0;
	logic host_oe = 1'h1, host_val = 1'h0, slow_edge_select_n = 1'h1;
	logic node_en = 1'h0, node_tx = 1'h1, pair_open = 1'h0;
	logic en_pin, f_out, f_oe, rx_data_out, rx_data_oe, line_lvl, line_fs, iso_rx;
	logic slow_act, drv_y, drv_z, drv_oe, fifo_rdy;
	irlc_fault_t fault_in = 3'h0;
	int n_fail = 0, num_checks = 0;
	// Host drive is strong and beats the weak fault drive on the pin
	assign en_pin = host_oe ? host_val : (f_oe ? f_out : 1'h1);
	irlc_top i_irlc_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .tx_data_in(tx_data_in),
		.tx_drive_enable(tx_drive_enable), .rx_out_enable_fault_in(en_pin),
		.rx_out_enable_fault_out(f_out), .rx_out_enable_fault_oe(f_oe),
		.rx_data_out(rx_data_out), .rx_data_oe(rx_data_oe), .line_rx_level(line_lvl),
		.line_rx_failsafe(line_fs), .iso_rx_data_out(iso_rx),
		.slow_edge_select_n(slow_edge_select_n), .slow_edge_active(slow_act),
		.drv_y_out(drv_y), .drv_z_out(drv_z), .drv_oe(drv_oe), .fault_in(fault_in),
		.fifo_in_ready(fifo_rdy));
	irlc_line_node i_irlc_line_node (.sys_clk(sys_clk), .drv_y_out(drv_y), .drv_oe(drv_oe),
		.node_en(node_en), .node_tx(node_tx), .pair_open(pair_open),
		.line_rx_level(line_lvl), .line_rx_failsafe(line_fs));
	// 100 ns clock
	initial begin
		forever #50 sys_clk = !sys_clk;
	end
	task automatic wrap_up;
		if (n_fail == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic seen, input logic exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
		end
	endtask
	// Inputs always move a fixed 10 ns after the edge
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#10;
	endtask
	function automatic logic sig(input int which);
		case (which)
			0: return drv_oe;
			1: return drv_y;
			2: return rx_data_out;
			default: return f_out;
		endcase
	endfunction
	// Bounded wait; running out counts as a mismatch and ends the run
	task automatic wait_for(input int which, input logic v, input int lim);
		int k;
		for (k = 0; k < lim && sig(which) !== v; k++) step(1);
		if (sig(which) !== v) begin
			chk("wait bound", sig(which), v);
			wrap_up();
		end
	endtask
	task automatic t_reset;
		chk("rx_data_out", rx_data_out, 1'h1);
		chk("drv_oe", drv_oe, 1'h0);
		chk("fault_out", f_out, 1'h1);
	endtask
	task automatic t_slow;
		slow_edge_select_n = 1'h0;
		step(2);
		chk("slow_edge_active", slow_act, 1'h1);
		slow_edge_select_n = 1'h1;
		step(2);
		chk("slow_edge_active", slow_act, 1'h0);
	endtask
	// Enable, data both ways, then disable with a lower bound on the delay
	task automatic t_drive;
		tx_data_in = 1'h1;
		tx_drive_enable = 1'h1;
		wait_for(0, 1'h1, 80);
		chk("drv_y", drv_y, 1'h1);
		chk("drv_z", drv_z, 1'h0);
		tx_data_in = 1'h0;
		wait_for(1, 1'h0, 16);
		chk("drv_z", drv_z, 1'h1);
		tx_drive_enable = 1'h0;
		step(6);
		chk("drv_oe early", drv_oe, 1'h1);
		wait_for(0, 1'h0, 12);
	endtask
	task automatic t_receive;
		node_en = 1'h1;
		node_tx = 1'h0;
		step(2);
		chk("iso_rx", iso_rx, 1'h0);
		chk("rx_data_oe", rx_data_oe, 1'h1);
		wait_for(2, 1'h0, 20);
		host_oe = 1'h0;
		step(2);
		chk("fault_out", f_out, 1'h0);
		chk("rx_data_oe", rx_data_oe, 1'h1);
		chk("fault_oe", f_oe, 1'h1);
		host_oe = 1'h1;
		host_val = 1'h1;
		step(2);
		chk("rx_data_oe", rx_data_oe, 1'h0);
		node_tx = 1'h1;
		step(2);
		chk("iso_rx", iso_rx, 1'h1);
		host_val = 1'h0;
	endtask
	task automatic t_open;
		node_en = 1'h0;
		node_tx = 1'h0;
		pair_open = 1'h1;
		wait_for(2, 1'h1, 20);
		step(20);
		chk("fault_out", f_out, 1'h0);
		chk("iso_rx", iso_rx, 1'h1);
		pair_open = 1'h0;
	endtask
	// Each cause alone; a held fault also fills the barrier buffer
	task automatic t_faults;
		int i;
		tx_drive_enable = 1'h1;
		for (i = 0; i < 3; i++) begin
			wait_for(3, 1'h0, 80);
			wait_for(0, 1'h1, 40);
			fault_in = irlc_fault_t'(3'h4 >> i);
			step(2);
			chk("fault_out", f_out, 1'h1);
			chk("rx_data_out", rx_data_out, 1'h1);
			chk("drv_oe", drv_oe, 1'h0);
			step(70);
			chk("fifo_in_ready", fifo_rdy, 1'h0);
			fault_in = 3'h0;
			step(5);
			chk("fault_out restart", f_out, 1'h1);
			wait_for(3, 1'h0, 60);
			wait_for(0, 1'h1, 60);
			chk("fifo_in_ready", fifo_rdy, 1'h1);
		end
	endtask
	initial begin
		step(6);
		sys_rst = 1'h0;
		t_reset();
		t_slow();
		t_drive();
		t_receive();
		t_open();
		t_faults();
		wrap_up();
	end
	// Guard against a hang anywhere in the sequence
	initial begin
		#5000000;
		n_fail++;
		wrap_up();
	end
endmodule
